//--- logic/tms_defs.vh
// Constants of the transmitter mode sequencer: offsets, fields, presets
// and timing figures. Assumes a 25 MHz system clock.
`ifndef TMS_DEFS_VH
`define TMS_DEFS_VH

////////////////////////////////////////////////////////////////////////
// Register offsets (byte addresses, one 32-bit word each)
`define TMS_OFS_APP         8'h00
`define TMS_OFS_FREQ        8'h04
`define TMS_OFS_STATUS      8'h08

////////////////////////////////////////////////////////////////////////
// Application settings field positions
`define TMS_APP_FORCE       15
`define TMS_APP_OOK         14
`define TMS_APP_BAND        13
`define TMS_APP_DEV_HI      12
`define TMS_APP_DEV_LO      5
`define TMS_APP_POWER       4
`define TMS_APP_IDLE        3

// Status field positions
`define TMS_ST_PRESET       7
`define TMS_ST_CFG          8
`define TMS_ST_READY        9

////////////////////////////////////////////////////////////////////////
// Preset values and reset values
`define TMS_APP_PRESET1     16'h20D4
`define TMS_APP_PRESET2     16'h401C
`define TMS_FREQ_PRESET1    19'h42CAD
`define TMS_FREQ_PRESET2    19'h42C1C
`define TMS_APP_RESET       16'h20D4
`define TMS_FREQ_RESET      19'h42CAD

// Synthesizer step as a power-of-two divisor of the reference
`define TMS_STEP_SHIFT_LOW  4'hE
`define TMS_STEP_SHIFT_HIGH 4'hD

// Configuration transfer length in select/clock cycles
`define TMS_CFG_CYCLES      5'h18

////////////////////////////////////////////////////////////////////////
// Timing figures in their own units
`define TMS_CLK_MHZ         25
`define TMS_START_US        200
`define TMS_WAKE_US         650
`define TMS_RAMP_US         20
`define TMS_HOP_LOW_US      500
`define TMS_HOP_HIGH_US     400
`define TMS_IDLE_SHORT_MS   2
`define TMS_IDLE_LONG_MS    20

`endif

//--- logic/tms_tx_mode_sequencer.v
// Operating-mode sequencer of a small FSK/OOK transmitter: power-up
// preset pick, wake-on-data, idle sleep, forced transmit and hops.
// Assumes select/clock and data pins are asynchronous to clk_in and a
// same-clock register master with one-cycle strobes.
//
// Implementation choices: the plain strobed port and the address map.
`include "tms_defs.vh"
`timescale 1ns/1ps
`default_nettype none

module tms_tx_mode_sequencer #(
    parameter OSC_START_US = 1000,  // Crystal dependent, plain default
    parameter [19:0] START_CYC =
        (`TMS_START_US + OSC_START_US) * `TMS_CLK_MHZ,
    parameter [19:0] WAKE_CYC =
        (`TMS_WAKE_US - `TMS_RAMP_US) * `TMS_CLK_MHZ,
    parameter [19:0] RELOCK_LOW_CYC =
        (`TMS_HOP_LOW_US - 2 * `TMS_RAMP_US) * `TMS_CLK_MHZ,
    parameter [19:0] RELOCK_HIGH_CYC =
        (`TMS_HOP_HIGH_US - 2 * `TMS_RAMP_US) * `TMS_CLK_MHZ,
    parameter [19:0] IDLE_SHORT_CYC =
        `TMS_IDLE_SHORT_MS * 1000 * `TMS_CLK_MHZ,
    parameter [19:0] IDLE_LONG_CYC =
        `TMS_IDLE_LONG_MS * 1000 * `TMS_CLK_MHZ
)(
    // Clock and reset
    input  wire        clk_in,
    input  wire        nrst_in,
    // Pins from the host
    input  wire        ctrl_pin_in,
    input  wire        data_pin_in,
    // Register port
    input  wire [7:0]  reg_addr_in,
    input  wire [31:0] reg_wdata_in,
    input  wire        reg_wr_in,
    input  wire        reg_rd_in,
    output reg  [31:0] reg_rdata_out,
    // Transmitter status and controls
    output wire        tx_ready_out,
    output reg         mod_data_out,
    output wire        awake_out,
    output wire        pa_on_out,
    output wire        pa_ramp_up_out,
    output wire        pa_ramp_down_out,
    output wire        pll_relock_out,
    output wire        cfg_busy_out,
    output reg         preset_two_out,
    // Synthesizer and modulator settings
    output wire [18:0] carrier_freq_out,
    output wire [7:0]  deviation_out,
    output wire [3:0]  step_shift_out,
    output wire        band_high_out,
    output wire        ook_out,
    output wire        power_high_out
);

    localparam [19:0] RAMP_CYC = `TMS_RAMP_US * `TMS_CLK_MHZ;
    localparam [19:0] ONE      = 20'h00001;

    localparam [6:0] ST_BOOT   = 7'h01;
    localparam [6:0] ST_SLEEP  = 7'h02;
    localparam [6:0] ST_WAKE   = 7'h04;
    localparam [6:0] ST_RUP    = 7'h08;
    localparam [6:0] ST_TX     = 7'h10;
    localparam [6:0] ST_RDN    = 7'h20;
    localparam [6:0] ST_RELOCK = 7'h40;

    ////////////////////////////////////////////////////////////////////
    // Pin synchronisers and edge detection

    reg ctrl_s1_ff;
    reg ctrl_s2_ff;
    reg ctrl_d_ff;
    reg data_s1_ff;
    reg data_s2_ff;
    reg data_d_ff;

    always @(posedge clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            ctrl_s1_ff <= 1'b0;
            ctrl_s2_ff <= 1'b0;
            ctrl_d_ff  <= 1'b0;
            data_s1_ff <= 1'b0;
            data_s2_ff <= 1'b0;
            data_d_ff  <= 1'b0;
        end
        else
        begin
            ctrl_s1_ff <= ctrl_pin_in;
            ctrl_s2_ff <= ctrl_s1_ff;
            ctrl_d_ff  <= ctrl_s2_ff;
            data_s1_ff <= data_pin_in;
            data_s2_ff <= data_s1_ff;
            data_d_ff  <= data_s2_ff;
        end
    end

    wire ctrl_rise = ctrl_s2_ff & ~ctrl_d_ff;
    wire ctrl_fall = ~ctrl_s2_ff & ctrl_d_ff;
    wire data_rise = data_s2_ff & ~data_d_ff;
    wire data_edge = data_s2_ff ^ data_d_ff;

    ////////////////////////////////////////////////////////////////////
    // Registers

    reg  [6:0]  state_ff;
    reg  [6:0]  nxt_state;
    reg  [19:0] tmr_ff;
    reg  [19:0] nxt_tmr;
    reg  [15:0] app_ff;
    reg  [18:0] freq_ff;
    reg         hop_ff;
    reg         cfg_ff;
    reg  [4:0]  cfg_cnt_ff;

    wire wr_app    = reg_wr_in && (reg_addr_in == `TMS_OFS_APP);
    wire wr_freq   = reg_wr_in && (reg_addr_in == `TMS_OFS_FREQ);
    wire boot_done = (state_ff == ST_BOOT) && (tmr_ff == 20'h00000);
    wire forced    = app_ff[`TMS_APP_FORCE];
    wire band_high = app_ff[`TMS_APP_BAND];
    wire tmr_zero  = (tmr_ff == 20'h00000);

    // Preset pick happens once, on the clock after the start delay
    always @(posedge clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            app_ff         <= `TMS_APP_RESET;
            freq_ff        <= `TMS_FREQ_RESET;
            preset_two_out <= 1'b0;
        end
        else if (boot_done)
        begin
            preset_two_out <= ctrl_s2_ff;
            app_ff  <= ctrl_s2_ff ? `TMS_APP_PRESET2
                                  : `TMS_APP_PRESET1;
            freq_ff <= ctrl_s2_ff ? `TMS_FREQ_PRESET2
                                  : `TMS_FREQ_PRESET1;
        end
        else
        begin
            if (wr_app)
                app_ff <= reg_wdata_in[15:0];
            if (wr_freq)
                freq_ff <= reg_wdata_in[18:0];
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Configuration transfer tracking on the select/clock pin

    always @(posedge clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            cfg_ff     <= 1'b0;
            cfg_cnt_ff <= 5'h00;
        end
        else if (!cfg_ff)
        begin
            // Edges before the preset pick are part of the strap, not config
            if (ctrl_rise && !data_s2_ff && (state_ff != ST_BOOT))
            begin
                cfg_ff     <= 1'b1;
                cfg_cnt_ff <= 5'h01;
            end
        end
        else if (ctrl_rise && (cfg_cnt_ff != `TMS_CFG_CYCLES))
            cfg_cnt_ff <= cfg_cnt_ff + 5'h01;
        else if (ctrl_fall && (cfg_cnt_ff == `TMS_CFG_CYCLES))
            cfg_ff <= 1'b0;
    end

    ////////////////////////////////////////////////////////////////////
    // Mode sequencer

    function [19:0] load_for;
        input [6:0] st;
        input       idle_long;
        input       band;
        begin
            case (st)
                ST_WAKE:   load_for = WAKE_CYC - ONE;
                ST_RUP:    load_for = RAMP_CYC - ONE;
                ST_RDN:    load_for = RAMP_CYC - ONE;
                ST_RELOCK: load_for = band ? RELOCK_HIGH_CYC - ONE
                                           : RELOCK_LOW_CYC - ONE;
                ST_TX:     load_for = idle_long ? IDLE_LONG_CYC - ONE
                                                : IDLE_SHORT_CYC - ONE;
                default:   load_for = 20'h00000;
            endcase
        end
    endfunction

    always @*
    begin
        nxt_state = state_ff;
        case (state_ff)
            ST_BOOT:
                if (tmr_zero)
                    nxt_state = ST_SLEEP;
            ST_SLEEP:
                if (forced)
                    nxt_state = ST_WAKE;
                else if (data_rise)
                    nxt_state = ST_WAKE;
            ST_WAKE:
                if (tmr_zero)
                    nxt_state = ST_RUP;
            ST_RUP:
                if (tmr_zero)
                    nxt_state = ST_TX;
            ST_TX:
                if (wr_freq)
                    nxt_state = ST_RDN;
                else if (forced)
                    nxt_state = ST_TX;
                else if (tmr_zero && !data_edge)
                    nxt_state = ST_RDN;
            ST_RDN:
                if (tmr_zero)
                    nxt_state = hop_ff ? ST_RELOCK : ST_SLEEP;
            ST_RELOCK:
                if (tmr_zero)
                    nxt_state = ST_RUP;
            default:
                nxt_state = ST_SLEEP;
        endcase
    end

    // Leaving forced transmit with the force bit cleared also lands on
    // the idle check, so a cleared bit with an expired timer turns off
    always @*
    begin
        nxt_tmr = tmr_ff;
        if (nxt_state != state_ff)
            nxt_tmr = load_for(nxt_state, app_ff[`TMS_APP_IDLE], band_high);
        else if ((state_ff == ST_TX) && data_edge)
            nxt_tmr = load_for(ST_TX, app_ff[`TMS_APP_IDLE],
                               band_high);
        else if (!tmr_zero)
            nxt_tmr = tmr_ff - ONE;
    end

    always @(posedge clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            state_ff <= ST_BOOT;
            tmr_ff   <= START_CYC - ONE;
            hop_ff   <= 1'b0;
        end
        else
        begin
            state_ff <= nxt_state;
            tmr_ff   <= nxt_tmr;
            // A hop request only counts while transmitting
            if ((state_ff == ST_TX) && wr_freq)
                hop_ff <= 1'b1;
            else if (state_ff == ST_RELOCK)
                hop_ff <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Modulator input and register read-back

    wire [31:0] status_word = {22'h000000,
                               (state_ff == ST_TX),
                               cfg_ff,
                               preset_two_out,
                               state_ff};

    always @(posedge clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            mod_data_out  <= 1'b0;
            reg_rdata_out <= 32'h00000000;
        end
        else
        begin
            mod_data_out <= (state_ff == ST_TX) && !cfg_ff
                            && data_s2_ff;
            if (!reg_rd_in)
                reg_rdata_out <= 32'h00000000;
            else
                case (reg_addr_in)
                    `TMS_OFS_APP:    reg_rdata_out <= {16'h0000, app_ff};
                    `TMS_OFS_FREQ:   reg_rdata_out <= {13'h0000, freq_ff};
                    `TMS_OFS_STATUS: reg_rdata_out <= status_word;
                    default:         reg_rdata_out <= 32'h00000000;
                endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Outputs

    assign tx_ready_out     = (state_ff == ST_TX);
    assign awake_out        = (state_ff != ST_BOOT) && (state_ff != ST_SLEEP);
    assign pa_ramp_up_out   = (state_ff == ST_RUP);
    assign pa_ramp_down_out = (state_ff == ST_RDN);
    assign pa_on_out        = pa_ramp_up_out | tx_ready_out | pa_ramp_down_out;
    assign pll_relock_out   = (state_ff == ST_RELOCK);
    assign cfg_busy_out     = cfg_ff;
    assign carrier_freq_out = freq_ff;
    assign deviation_out    = app_ff[`TMS_APP_DEV_HI:`TMS_APP_DEV_LO];
    assign band_high_out    = band_high;
    assign step_shift_out   = band_high ? `TMS_STEP_SHIFT_HIGH
                                        : `TMS_STEP_SHIFT_LOW;
    assign ook_out          = app_ff[`TMS_APP_OOK];
    assign power_high_out   = app_ff[`TMS_APP_POWER];

endmodule // tms_tx_mode_sequencer

`default_nettype wire

//--- testbench/tms_seq_assertions.sv
// Checker of the transmitter mode sequencer: timing at its ports.
// Assumes one clk_in domain and the fixed 500-cycle amplifier ramp.
`timescale 1ns/1ps
`default_nettype none

module tms_seq_checker #(
    parameter [19:0] WAKE_CYC        = 20'h0000A,
    parameter [19:0] RELOCK_LOW_CYC  = 20'h00008,
    parameter [19:0] RELOCK_HIGH_CYC = 20'h00006
)(
    // Clock and reset
    input wire logic        clk_in,
    input wire logic        nrst_in,
    // Register port
    input wire logic        reg_rd_in,
    input wire logic [31:0] reg_rdata_out,
    // Status and controls
    input wire logic        tx_ready_out,
    input wire logic        mod_data_out,
    input wire logic        awake_out,
    input wire logic        pa_on_out,
    input wire logic        pa_ramp_up_out,
    input wire logic        pa_ramp_down_out,
    input wire logic        pll_relock_out,
    input wire logic        cfg_busy_out,
    input wire logic [3:0]  step_shift_out,
    input wire logic        band_high_out
);
    localparam int WLO = WAKE_CYC + 498;
    localparam int WHI = WAKE_CYC + 503;
    logic [2:0]  ph_ff;
    logic [19:0] cnt_ff;

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!nrst_in);

    ////////////////////////////////////////////////////////////////////////
    // Length of the ramp or relock phase now running
    always_ff @(posedge clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            ph_ff  <= 3'h0;
            cnt_ff <= 20'h00000;
        end
        else
        begin
            ph_ff  <= {pa_ramp_up_out, pa_ramp_down_out, pll_relock_out};
            cnt_ff <= (ph_ff != {pa_ramp_up_out, pa_ramp_down_out,
                pll_relock_out}) ? 20'h00001 : cnt_ff + 20'h00001;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    a_ready_pa: assert property (tx_ready_out |-> pa_on_out &&
        !pa_ramp_up_out && !pa_ramp_down_out)
        else $error("ready while amplifier not settled");
    a_mod_idle: assert property (!tx_ready_out &&
        !$past(tx_ready_out) |-> !mod_data_out)
        else $error("modulator driven outside transmit");
    a_cfg_block: assert property (cfg_busy_out &&
        $past(cfg_busy_out) |-> !mod_data_out)
        else $error("modulator driven during config");
    a_ramp_len: assert property ($fell(pa_ramp_up_out) ||
        $fell(pa_ramp_down_out) |-> cnt_ff == 20'h001F4)
        else $error("amplifier ramp not 500 cycles");
    a_relock_len: assert property ($fell(pll_relock_out) |->
        cnt_ff == (band_high_out ? RELOCK_HIGH_CYC : RELOCK_LOW_CYC))
        else $error("relock length wrong for band");
    a_hop_order: assert property ($rose(pll_relock_out) |->
        $past(pa_ramp_down_out) && !pa_on_out ##1 pll_relock_out)
        else $error("relock not after ramp down");
    a_relock_up: assert property ($fell(pll_relock_out) |->
        pa_ramp_up_out)
        else $error("no ramp up after relock");
    a_wake_ready: assert property ($rose(awake_out) |->
        ##[WLO:WHI] tx_ready_out)
        else $error("ready not at end of start-up");
    a_sleep_rdn: assert property ($fell(awake_out) |->
        $past(pa_ramp_down_out))
        else $error("sleep without ramp down");
    a_rdata_idle: assert property (!$past(reg_rd_in) |->
        reg_rdata_out == 32'h00000000)
        else $error("read data outside read cycle");
    a_step_band: assert property (step_shift_out ==
        (band_high_out ? 4'hD : 4'hE))
        else $error("step divisor wrong for band");

    c_ready: cover property ($rose(tx_ready_out));
    c_hop: cover property ($fell(pll_relock_out));
    c_cfg: cover property ($rose(cfg_busy_out));
endmodule // tms_seq_checker

bind tms_tx_mode_sequencer tms_seq_checker #(
    .WAKE_CYC(WAKE_CYC), .RELOCK_LOW_CYC(RELOCK_LOW_CYC),
    .RELOCK_HIGH_CYC(RELOCK_HIGH_CYC)) u_chk (
    .clk_in(clk_in), .nrst_in(nrst_in), .reg_rd_in(reg_rd_in),
    .reg_rdata_out(reg_rdata_out), .tx_ready_out(tx_ready_out),
    .mod_data_out(mod_data_out), .awake_out(awake_out),
    .pa_on_out(pa_on_out), .pa_ramp_up_out(pa_ramp_up_out),
    .pa_ramp_down_out(pa_ramp_down_out), .pll_relock_out(pll_relock_out),
    .cfg_busy_out(cfg_busy_out), .step_shift_out(step_shift_out),
    .band_high_out(band_high_out));
`default_nettype wire

//--- testbench/tms_host_model.sv
// Host model: drives the select/clock and data pins of the sequencer.
// Assumes the bench calls its tasks; select/clock runs only in transfers.
`timescale 1ns/1ps
`default_nettype none

module tms_host_model #(
    parameter int CFG_WAIT = 25000
)(
    // Clock and reset
    input  wire logic clk_in,
    input  wire logic nrst_in,
    // Pins
    output var  logic ctrl_pin_out,
    output var  logic data_pin_out
);
    int since_ff;

    always @(posedge clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
            since_ff <= 0;
        else if (since_ff < CFG_WAIT)
            since_ff <= since_ff + 1;
    end

    initial
    begin
        ctrl_pin_out = 1'b0;
        data_pin_out = 1'b0;
    end

    task pins(input logic c, input logic d);
        @(posedge clk_in);
        ctrl_pin_out <= c;
        data_pin_out <= d;
    endtask

    // 1 ms at 25 MHz before the first transfer edge
    task settle();
        while (since_ff < CFG_WAIT)
            @(posedge clk_in);
    endtask

    // 320 ns select/clock; data set up half a period before each rise
    task xfer(input logic d0, input int edges);
        for (int i = 0; i < edges; i++)
        begin
            pins(1'b0, i == 0 ? d0 : ~data_pin_out);
            repeat (3) @(posedge clk_in);
            pins(1'b1, data_pin_out);
            repeat (3) @(posedge clk_in);
        end
        pins(1'b0, data_pin_out);
    endtask

    // Recovery pulses on data only: 4 us high, 5.2 us low, twice
    task recover();
        repeat (2)
        begin
            pins(1'b0, 1'b1);
            repeat (99) @(posedge clk_in);
            pins(1'b0, 1'b0);
            repeat (129) @(posedge clk_in);
        end
    endtask
endmodule // tms_host_model
`default_nettype wire

//--- testbench/tb_tx_mode_sequencer.sv
// Bench of the transmitter mode sequencer: presets, wake, idle sleep,
// forced transmit, config blocking and hops against a small model.
// Assumes the bound checker and the host pin model beside the design.
`timescale 1ns/1ps
`default_nettype none

module tb_tx_mode_sequencer;
    // High band relock keeps its full length: 400 us less two ramps
    localparam int WAKE = 10, RLO = 8, ISH = 200, ILG = 400;
    localparam int RHI = (400 - 2 * 20) * 25;
    localparam int RAMP = 500;
    logic        clk_in = 1'b0, nrst_in = 1'b0, reg_wr_in = 1'b0;
    logic        reg_rd_in = 1'b0, ctrl_pin, data_pin, seen, busy;
    logic        rdy, mod, awake, band, ook, pwr, p2;
    logic [7:0]  reg_addr_in = 8'h00, dev;
    logic [3:0]  step;
    logic [18:0] carrier;
    logic [31:0] reg_wdata_in = 32'h0, rdata, rng = 32'h00017B7E;
    int          n_errors = 0, compares = 0, cyc = 0, n, exp_app, exp_freq;

    always #20 clk_in = ~clk_in;
    always @(posedge clk_in)
    begin
        cyc++;
        if (cyc == 80000)
        begin
            n_errors++;
            test_done();
        end
    end

    tms_tx_mode_sequencer #(.START_CYC(20'h00014), .WAKE_CYC(20'h0000A),
        .RELOCK_LOW_CYC(20'h00008),
        .IDLE_SHORT_CYC(20'h000C8), .IDLE_LONG_CYC(20'h00190)) DUT (
        .clk_in(clk_in), .nrst_in(nrst_in), .ctrl_pin_in(ctrl_pin),
        .data_pin_in(data_pin), .reg_addr_in(reg_addr_in),
        .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in),
        .reg_rd_in(reg_rd_in), .reg_rdata_out(rdata), .tx_ready_out(rdy),
        .mod_data_out(mod), .awake_out(awake), .pa_on_out(),
        .pa_ramp_up_out(), .pa_ramp_down_out(), .pll_relock_out(),
        .cfg_busy_out(busy), .preset_two_out(p2), .carrier_freq_out(carrier),
        .deviation_out(dev), .step_shift_out(step), .band_high_out(band),
        .ook_out(ook), .power_high_out(pwr));
    tms_host_model host (.clk_in(clk_in), .nrst_in(nrst_in),
        .ctrl_pin_out(ctrl_pin), .data_pin_out(data_pin));

    ////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] xs();
        rng = rng ^ (rng << 13);
        rng = rng ^ (rng >> 17);
        rng = rng ^ (rng << 5);
        return rng;
    endfunction

    task chk(input logic [31:0] got, input logic [31:0] want);
        compares++;
        if (got !== want)
        begin
            n_errors++;
            $display("Error at %0t: got %h, expected %h", $time, got, want);
        end
    endtask

    task wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_in);
        reg_addr_in <= a;
        reg_wdata_in <= d;
        reg_wr_in <= 1'b1;
        @(posedge clk_in);
        reg_wr_in <= 1'b0;
    endtask

    task rd(input logic [7:0] a, input logic [31:0] want);
        @(posedge clk_in);
        reg_addr_in <= a;
        reg_rd_in <= 1'b1;
        @(posedge clk_in);
        reg_rd_in <= 1'b0;
        #1 chk(rdata, want);
    endtask

    // Cycles until ready reaches lvl; a small window allows for the sync
    task wait_rdy(input logic lvl, input int want);
        n = 0;
        while (rdy !== lvl && n < 12000)
        begin
            @(posedge clk_in);
            #1 n++;
        end
        chk((n >= want - 2 && n <= want + 6) ? want : n, want);
    endtask

    task watch(input int k);
        seen = 1'b0;
        repeat (k)
        begin
            @(posedge clk_in);
            #1 seen = seen | busy;
        end
    endtask

    task reset_dut(input logic p);
        host.pins(p, 1'b0);
        nrst_in <= 1'b0;
        repeat (12) @(posedge clk_in);
        nrst_in <= 1'b1;
        repeat (40) @(posedge clk_in);
        exp_app = p ? 'h401C : 'h20D4;
        exp_freq = p ? 'h42C1C : 'h42CAD;
    endtask

    task outs(input logic p);
        #1 chk({carrier, dev, step}, {exp_freq[18:0], exp_app[12:5],
            exp_app[13] ? 4'hD : 4'hE});
        chk({band, ook, pwr, p2}, {exp_app[13], exp_app[14], exp_app[4], p});
        rd(8'h00, exp_app);
        rd(8'h04, exp_freq);
    endtask

    task test_done();
        $display("Comparisons %0d, mismatches %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        for (int p = 0; p < 2; p++)
        begin
            reset_dut(p[0]);
            outs(p[0]);
            rd(8'h0C, 32'h0);
            wr(8'h08, 32'hFFFFFFFF);
            rd(8'h08, {24'h0, p[0], 7'h02});
            host.pins(1'b0, 1'b1);
            wait_rdy(1'b1, WAKE + RAMP + 3);
            repeat (16)
            begin
                rng = xs();
                host.pins(1'b0, rng[0]);
                repeat (6) @(posedge clk_in);
                #1 chk(mod, rng[0]);
            end
            host.pins(1'b0, 1'b1);
            repeat (8) @(posedge clk_in);
            host.pins(1'b0, 1'b0);
            wait_rdy(1'b0, (p ? ILG : ISH) + 3);
            repeat (RAMP + 10) @(posedge clk_in);
            #1 chk(awake, 1'b0);
            exp_app = exp_app | 'h8000;
            wr(8'h00, exp_app);
            wait_rdy(1'b1, WAKE + RAMP + 2);
            rd(8'h08, {22'h0, 2'b10, p[0], 7'h10});
            host.recover();
            host.settle();
            fork
                host.xfer(1'b0, 24);
                watch(200);
            join
            chk(seen, 1'b1);
            fork
                host.xfer(1'b1, 1);
                watch(20);
            join
            chk({seen, rdy}, 2'b01);
            exp_freq = xs() & 'h7FFFF;
            wr(8'h04, 32'hFFF80000 | exp_freq);
            wait_rdy(1'b0, 1);
            wait_rdy(1'b1, 2 * RAMP + (p ? RLO : RHI));
            outs(p[0]);
            exp_app = exp_app & 'h7FFF;
            wr(8'h00, exp_app);
            repeat (ILG + RAMP + 20) @(posedge clk_in);
            #1 chk(awake, 1'b0);
            $display("Preset %0d sequence done", p);
        end
        test_done();
    end
endmodule // tb_tx_mode_sequencer
`default_nettype wire
